// ---- serial_in_latched_driver_12bit_tb.sv ----
// Purpose: Self-checking bench for the serial-in latched driver.
// Assumes: The host model paces every shift.
// Notes: Each scenario judges the outputs before it returns.
`timescale 1ns/1ps
module serial_in_latched_driver_12bit_tb;
   import sld_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   sld_pins_type pins;
   logic serial_out;
   logic [11:0] drv_out;
   logic [11:0] drv_oe;
   int failures = 0;
   int total_checks = 0;
   // The clock has a 50 ns period.
   always #25 clk = ~clk;
   sld_host host (.clk(clk), .pins(pins));
   sld_driver #(.STAGES(SLD_STAGES)) dut (.clk(clk), .rst_b(rst_b), .pins(pins),
      .serial_out(serial_out), .driver_outputs(drv_out), .driver_outputs_oe(drv_oe));
   // Case equality, so an unknown never passes.
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Lets the synchroniser and registers catch up.
   task automatic settle();
      repeat (4) @(negedge clk);
   endtask
   // Shifts a word in, first bit to stage twelve.
   task automatic load(input logic [11:0] p);
      for (int i = 11; i >= 0; i--) begin
         host.shift_bit(p[i]);
      end
      settle();
   endtask
   // Load with drivers forced off, then enable them.
   task automatic t_load();
      load(12'hA5C);
      chk(drv_oe, 12'h000);
      chk({11'h000, serial_out}, 12'h001);
      host.set_ctl(1'b1, 1'b0);
      settle();
      chk(drv_oe, 12'hA5C);
      chk(drv_out, 12'h000);
   endtask
   // One more shift while transparent moves every output along.
   task automatic t_step();
      host.shift_bit(1'b1);
      settle();
      chk(drv_oe, 12'h4B9);
      chk({11'h000, serial_out}, 12'h000);
   endtask
   // Closed latches hold while shifting goes on, then show the new word.
   task automatic t_hold();
      host.set_ctl(1'b0, 1'b0);
      load(12'h8F0);
      chk(drv_oe, 12'h4B9);
      chk({11'h000, serial_out}, 12'h001);
      host.set_ctl(1'b1, 1'b0);
      settle();
      chk(drv_oe, 12'h8F0);
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic test_done();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // A run this short needs about 300 cycles; 3000 means a hang.
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      test_done();
   end
   // Reset for three cycles, then the scenarios.
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      t_load();
      t_step();
      t_hold();
      test_done();
   end
endmodule // serial_in_latched_driver_12bit_tb

// ---- sld_driver.sv ----
// Purpose: Twelve-stage serial-in shift register with latches and gated drivers.
// Assumes: The host shift clock is far slower than clk, so edges are seen reliably.
// Notes: Drivers are open-collector: enable high means the pin is pulled low.
`timescale 1ns/1ps
module sld_driver
   import sld_pkg::*;
#(
   parameter int STAGES = SLD_STAGES
) (
   input wire logic clk, // 20 MHz system clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire sld_pins_type pins, // Raw host pins.
   output logic serial_out, // Cascade output, last stage.
   output logic [STAGES-1:0] driver_outputs, // Driven level, always low.
   output logic [STAGES-1:0] driver_outputs_oe // High while pulling a pin low.
);
   sld_pins_type pins_s;
   logic [3:0] pins_s_vec;
   logic clk_prev_reg;
   logic clk_prev_next;
   logic shift_edge;
   logic [STAGES-1:0] shift_reg;
   logic [STAGES-1:0] shift_next;
   logic [STAGES-1:0] latch_reg;
   logic [STAGES-1:0] latch_next;
   logic [STAGES-1:0] drive_reg;
   logic [STAGES-1:0] drive_next;
   logic [STAGES-1:0] level_reg;
   logic serial_reg;
   logic serial_next;

   // Every pin is asynchronous to clk and is synchronised before use.
   sld_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .async_in(pins),
      .sync_out(pins_s_vec)
   );
   assign pins_s = sld_pins_type'(pins_s_vec);

   // Rising edge of the sampled shift clock acts as the shift enable.
   assign clk_prev_next = pins_s.shift_clk;
   assign shift_edge = pins_s.shift_clk & ~clk_prev_reg;

   // Shift chain, latches and driver gating.
   always_comb begin
      shift_next = shift_reg;
      if (shift_edge) begin
         shift_next = {shift_reg[STAGES-2:0], pins_s.serial_data};
      end
      // Latches look at the post-shift value so a new bit shows in the same step.
      latch_next = pins_s.latch_open ? shift_next : latch_reg;
      // A latched one switches the transistor on, which makes the pin low.
      drive_next = pins_s.outputs_off ? '0 : latch_next;
      serial_next = shift_next[STAGES-1];
   end

   // State registers; reset leaves every driver off for safety.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_prev_reg <= 1'b0;
         shift_reg <= SLD_REG_RESET[STAGES-1:0];
         latch_reg <= SLD_REG_RESET[STAGES-1:0];
         drive_reg <= '0;
         level_reg <= '0;
         serial_reg <= 1'b0;
      end else begin
         clk_prev_reg <= clk_prev_next;
         shift_reg <= shift_next;
         latch_reg <= latch_next;
         drive_reg <= drive_next;
         level_reg <= '0;
         serial_reg <= serial_next;
      end
   end

   assign serial_out = serial_reg;
   assign driver_outputs = level_reg;
   assign driver_outputs_oe = drive_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   shift_in_a: assert property (shift_edge |=> shift_reg[0] == $past(pins_s.serial_data))
      else $error("Serial data not captured on shift edge.");
   advance_stages_a: assert property (shift_edge |=>
      shift_reg[STAGES-1:1] == $past(shift_reg[STAGES-2:0]))
      else $error("Stages did not advance by one.");
   shift_hold_a: assert property (!shift_edge |=> shift_reg == $past(shift_reg))
      else $error("Shift register moved without an edge.");
   serial_cascade_a: assert property (shift_edge |=>
      serial_out == $past(shift_reg[STAGES-2]))
      else $error("Serial output not last stage after edge.");
   transparent_first_a: assert property (shift_edge && pins_s.latch_open && !pins_s.outputs_off
      |=> driver_outputs_oe[0] == $past(pins_s.serial_data))
      else $error("New bit did not reach driver one.");
   output_order_a: assert property (shift_edge && pins_s.latch_open && !pins_s.outputs_off
      |=> driver_outputs_oe[STAGES-1:1] == $past(shift_reg[STAGES-2:0]))
      else $error("Outputs did not follow shifting in order.");
   latch_hold_a: assert property (!pins_s.latch_open |=> $stable(latch_reg))
      else $error("Closed latch changed.");
   drivers_off_a: assert property (pins_s.outputs_off |=> driver_outputs_oe == '0)
      else $error("Drivers active while disabled.");
   inverted_out_a: assert property (!pins_s.outputs_off && !pins_s.latch_open
      |=> driver_outputs_oe == latch_reg && driver_outputs == '0)
      else $error("Driver state does not match latched bits.");

   // Two shift steps close together, as a word load produces.
   shift_seen_c: cover property (shift_edge ##[1:20] shift_edge);
   latch_close_c: cover property (pins_s.latch_open ##1 !pins_s.latch_open);
   enable_on_c: cover property (pins_s.outputs_off ##1 !pins_s.outputs_off ##1 |driver_outputs_oe);
endmodule // sld_driver

// ---- sld_host.sv ----
// Purpose: Host controller model that drives the driver's pins.
// Assumes: Pins change only just after a rising clk edge.
// Notes: The shift clock stands still between shifts.
`timescale 1ns/1ps
module sld_host
   import sld_pkg::*;
(
   input wire logic clk, // System clock.
   output sld_pins_type pins // Host pin levels.
);
   // Outputs stay off until a pattern is latched, since power-up state is unknown.
   initial begin
      pins = '{serial_data: 1'b0, shift_clk: 1'b0, latch_open: 1'b1, outputs_off: 1'b1};
   end
   // Five cycles high and six low between back-to-back shifts, and data is held across the rise.
   task automatic shift_bit(input logic b);
      @(posedge clk);
      pins.serial_data <= b;
      repeat (SLD_SHIFT_PULSE_CYC + 1) @(posedge clk);
      pins.shift_clk <= 1'b1;
      repeat (SLD_SHIFT_PULSE_CYC + 1) @(posedge clk);
      pins.shift_clk <= 1'b0;
   endtask
   // Sets the latch and enable levels together.
   task automatic set_ctl(input logic latch, input logic off);
      @(posedge clk);
      pins.latch_open <= latch;
      pins.outputs_off <= off;
   endtask
endmodule // sld_host

// ---- sld_pkg.sv ----
// Purpose: Shared constants and carrier types for the serial-in latched driver.
// Assumes: One 20 MHz system clock; every pin input is sampled before use.
// Notes: Twelve stages; outputs are open-collector, active when driving low.
package sld_pkg;
   localparam int SLD_STAGES = 12;
   localparam int SLD_SYNC_DEPTH = 2;
   localparam int SLD_SYS_PERIOD_NS = 50;
   localparam int SLD_SHIFT_PULSE_MIN_NS = 200;
   // Least shift-clock level time, rounded up to whole system cycles.
   localparam int SLD_SHIFT_PULSE_CYC =
      (SLD_SHIFT_PULSE_MIN_NS + SLD_SYS_PERIOD_NS - 1) / SLD_SYS_PERIOD_NS;
   localparam logic [11:0] SLD_REG_RESET = 12'h000;

   // Host-driven pins, grouped so they cross into the clock domain together.
   typedef struct packed {
      logic serial_data;
      logic shift_clk;
      logic latch_open;
      logic outputs_off;
   } sld_pins_type;
endpackage

// ---- sld_sync.sv ----
// Purpose: Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
module sld_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clk, // System clock.
   input wire logic rst_b, // Asynchronous reset, active low.
   input wire logic [WIDTH-1:0] async_in, // Raw pin levels.
   output logic [WIDTH-1:0] sync_out // Levels safe to read.
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // Next values: the second stage reads only the first.
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // Both stages clear on reset so downstream logic starts from a known level.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule // sld_sync
